// ==== inc/dts_pkg.sv ====
// package of constants and carrier types for the data tunnel slot window block
package dts_pkg;

  localparam int CNT_W = 6;

  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

  // slot position codes on the slot stream
  localparam logic [1:0] SLOT_IDLE   = 2'h0;
  localparam logic [1:0] SLOT_AUDIO  = 2'h1;
  localparam logic [1:0] SLOT_TUNNEL = 2'h2;

  // command issued by the local serial host
  localparam logic [7:0] CMD_ABORT = 8'h0A;

  typedef struct packed {
    logic             first_node;
    logic             last_node;
    logic             mask_enable;
    logic             relaxed;
    logic [CNT_W-1:0] offset;
    logic [CNT_W-1:0] tunnel_slots;
    logic [CNT_W-1:0] pass_slots;
  } dts_dir_cfg_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } dts_cmd_type;

  typedef struct packed {
    logic [1:0] kind;
    logic       tunnel;
    logic       last;
  } dts_slot_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LEAD,
    ST_TUNNEL,
    ST_TRAIL
  } dts_win_state_type;

endpackage

// ==== hw/dts_slot_window.sv ====
// tunnel slot placement in both slot streams plus serial abort handling
`timescale 1ns/100ps
// Operation
// - in relaxed mode tunnel slots are forwarded, never stripped.
// - abort while busy ends the transaction and flushes the transfer FIFO.
// - other command while busy is rejected, flags invalid, raises interrupt.
// - abort accepted whether or not this node owns the tunnel.
module dts_slot_window
  import dts_pkg::*;
#(
  parameter int CW = CNT_W
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            reset_n,
  // configuration, held stable while the slot windows are open
  input  wire dts_dir_cfg_type down_cfg,
  input  wire dts_dir_cfg_type up_cfg,
  // frame strobes and slot strobes from the bus framer
  input  wire logic            down_frame,
  input  wire logic            down_slot,
  input  wire logic            up_frame,
  input  wire logic            up_slot,
  // serial host side
  input  wire dts_cmd_type     host_cmd,
  input  wire logic            transfer_busy,
  input  wire logic            tunnel_busy,
  input  wire logic            clear_invalid,
  // slot markers out
  output dts_slot_type         down_mark,
  output dts_slot_type         up_mark,
  // status and control out
  output logic                 serial_port_busy,
  output logic                 tunnel_active,
  output logic                 invalid_command_flag,
  output logic                 cmd_irq,
  output logic                 abort_pulse,
  output logic                 fifo_flush
);

  typedef struct packed {
    dts_win_state_type dn_st;
    dts_win_state_type up_st;
    logic [CW-1:0]     dn_pos;
    logic [CW-1:0]     up_pos;
    dts_slot_type      dn_mark;
    dts_slot_type      up_mark;
    logic              busy;
    logic              active;
    logic              invalid;
    logic              irq;
    logic              abort;
    logic              flush;
  } dts_state_type;

  dts_state_type state;
  dts_state_type next_state;
  logic          rst_int_n;
  // reset release pair runs on the raw reset, so it stays apart from the state record
  logic [1:0]    rst_sync;

  // slot classification for one stream; tunnel slots form a consecutive run
  function automatic dts_slot_type classify(input dts_dir_cfg_type cfg,
                                            input logic [CW-1:0]   pos);
    dts_slot_type r;
    logic [CW:0]  tun_end;
    logic [CW:0]  all_end;
    tun_end = {1'b0, cfg.offset} + {1'b0, cfg.tunnel_slots};
    all_end = {1'b0, cfg.pass_slots} + {1'b0, cfg.tunnel_slots};
    r.tunnel = ({1'b0, pos} < tun_end) && (pos >= cfg.offset);
    // forwarded slots: passed audio plus the tunnel run kept in the stream
    r.kind = ({1'b0, pos} < all_end) ? (r.tunnel ? SLOT_TUNNEL : SLOT_AUDIO)
                                     : SLOT_IDLE;
    // a tunnel end node with mask_enable set strips the run unless relaxed placement is used
    if (r.tunnel && !cfg.relaxed && (cfg.first_node || cfg.last_node)
        && cfg.mask_enable) begin
      r.kind = SLOT_IDLE;
    end
    if (r.tunnel && cfg.relaxed) begin
      r.kind = SLOT_TUNNEL;
    end
    r.last = ({1'b0, pos} == all_end - {{CW{1'b0}}, 1'b1});
    return r;
  endfunction

  assign rst_int_n = rst_sync[1];

  always_comb begin
    next_state             = state;
    next_state.abort       = 1'b0;
    next_state.flush       = 1'b0;
    next_state.irq         = 1'b0;
    next_state.busy        = transfer_busy;
    next_state.active      = tunnel_busy;
    // downstream window
    if (down_frame) begin
      next_state.dn_pos  = CW'(CNT_ZERO);
      next_state.dn_st   = ST_LEAD;
      next_state.dn_mark = '0;
    end else if (down_slot && state.dn_st != ST_IDLE) begin
      next_state.dn_mark = classify(down_cfg, state.dn_pos);
      next_state.dn_pos  = state.dn_pos + CW'(CNT_ONE);
      next_state.dn_st   = next_state.dn_mark.last ? ST_IDLE
                         : (next_state.dn_mark.tunnel ? ST_TUNNEL : ST_TRAIL);
    end
    // upstream window
    if (up_frame) begin
      next_state.up_pos  = CW'(CNT_ZERO);
      next_state.up_st   = ST_LEAD;
      next_state.up_mark = '0;
    end else if (up_slot && state.up_st != ST_IDLE) begin
      next_state.up_mark = classify(up_cfg, state.up_pos);
      next_state.up_pos  = state.up_pos + CW'(CNT_ONE);
      next_state.up_st   = next_state.up_mark.last ? ST_IDLE
                         : (next_state.up_mark.tunnel ? ST_TUNNEL : ST_TRAIL);
    end
    // serial host commands, no owner check on abort
    if (clear_invalid) begin
      next_state.invalid = 1'b0;
    end
    if (host_cmd.valid && state.busy) begin
      if (host_cmd.code == CMD_ABORT) begin
        next_state.abort = 1'b1;
        next_state.flush = 1'b1;
      end else begin
        next_state.invalid = 1'b1;
        next_state.irq     = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state.dn_st   <= ST_IDLE;
      state.up_st   <= ST_IDLE;
      state.dn_pos  <= CW'(CNT_ZERO);
      state.up_pos  <= CW'(CNT_ZERO);
      state.dn_mark <= '0;
      state.up_mark <= '0;
      state.busy    <= 1'b0;
      state.active  <= 1'b0;
      state.invalid <= 1'b0;
      state.irq     <= 1'b0;
      state.abort   <= 1'b0;
      state.flush   <= 1'b0;
    end else begin
      state.dn_st   <= next_state.dn_st;
      state.up_st   <= next_state.up_st;
      state.dn_pos  <= next_state.dn_pos;
      state.up_pos  <= next_state.up_pos;
      state.dn_mark <= next_state.dn_mark;
      state.up_mark <= next_state.up_mark;
      state.busy    <= next_state.busy;
      state.active  <= next_state.active;
      state.invalid <= next_state.invalid;
      state.irq     <= next_state.irq;
      state.abort   <= next_state.abort;
      state.flush   <= next_state.flush;
    end
  end

  assign down_mark            = state.dn_mark;
  assign up_mark              = state.up_mark;
  assign serial_port_busy     = state.busy;
  assign tunnel_active        = state.active;
  assign invalid_command_flag = state.invalid;
  assign cmd_irq              = state.irq;
  assign abort_pulse          = state.abort;
  assign fifo_flush           = state.flush;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_abort_in;
    host_cmd.valid && serial_port_busy && host_cmd.code == CMD_ABORT;
  endsequence
  sequence s_flushed;
    abort_pulse && fifo_flush && !cmd_irq;
  endsequence
  property p_abort;
    @(posedge ref_clk) disable iff (!rst_int_n) s_abort_in |=> s_flushed;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not flush");
  property p_invalid_command_flag;
    @(posedge ref_clk) disable iff (!rst_int_n)
      host_cmd.valid && serial_port_busy && host_cmd.code != CMD_ABORT
      |=> invalid_command_flag && cmd_irq && !abort_pulse;
  endproperty
  a_invalid_command_flag: assert property (p_invalid_command_flag) else $error("bad command not flagged");
  property p_set_wins;
    @(posedge ref_clk) disable iff (!rst_int_n)
      clear_invalid && host_cmd.valid && serial_port_busy && host_cmd.code != CMD_ABORT
      |=> invalid_command_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat set");
  property p_idle_abort;
    @(posedge ref_clk) disable iff (!rst_int_n) !serial_port_busy |=> !abort_pulse;
  endproperty
  a_idle_abort: assert property (p_idle_abort) else $error("abort while idle");
  property p_relaxed_keep;
    @(posedge ref_clk) disable iff (!rst_int_n)
      down_slot && !down_frame && state.dn_st != ST_IDLE && down_cfg.relaxed
      && state.dn_pos >= down_cfg.offset
      && {1'b0, state.dn_pos} < {1'b0, down_cfg.offset} + {1'b0, down_cfg.tunnel_slots}
      |=> down_mark.tunnel && down_mark.kind == SLOT_TUNNEL;
  endproperty
  a_relaxed_keep: assert property (p_relaxed_keep) else $error("tunnel slot stripped");
  property p_before_offset;
    @(posedge ref_clk) disable iff (!rst_int_n)
      up_slot && !up_frame && state.up_st != ST_IDLE && state.up_pos < up_cfg.offset
      |=> !up_mark.tunnel;
  endproperty
  a_before_offset: assert property (p_before_offset) else $error("tunnel too early");
  property p_frame_restart;
    @(posedge ref_clk) disable iff (!rst_int_n)
      down_frame |=> state.dn_pos == CNT_ZERO && !down_mark.tunnel;
  endproperty
  a_frame_restart: assert property (p_frame_restart) else $error("no frame restart");
  property p_busy_follow;
    @(posedge ref_clk) disable iff (!rst_int_n)
      transfer_busy && tunnel_busy |=> serial_port_busy && tunnel_active;
  endproperty
  a_busy_follow: assert property (p_busy_follow) else $error("busy not shown");

endmodule

// ==== dv/dts_framer.sv ====
// far-side model: frame markers and slot strobes for both slot streams
`timescale 1ns/100ps
module dts_framer (
  // clock
  input  wire logic       ref_clk,
  // request from the bench
  input  wire logic       start,
  input  wire logic       slow,
  input  wire logic [5:0] n_down,
  input  wire logic [5:0] n_up,
  // slot streams
  output logic            down_frame,
  output logic            down_slot,
  output logic            up_frame,
  output logic            up_slot,
  output logic            busy
);
  initial begin
    {down_frame, down_slot, up_frame, up_slot, busy} = 5'h00;
    forever begin
      @(posedge ref_clk);
      if (start) begin
        @(negedge ref_clk);
        busy = 1'b1;
        {down_frame, up_frame} = 2'h3;
        @(negedge ref_clk);
        {down_frame, up_frame} = 2'h0;
        // slots from the first data slot after the marker, one per cycle, or every other cycle when slow
        for (int i = 0; i < int'(n_down) || i < int'(n_up); i++) begin
          down_slot = (i < int'(n_down));
          up_slot = (i < int'(n_up));
          @(negedge ref_clk);
          if (slow) begin
            {down_slot, up_slot} = 2'h0;
            @(negedge ref_clk);
          end
        end
        {down_slot, up_slot, busy} = 3'h0;
      end
    end
  end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench for the tunnel slot window block
`timescale 1ns/100ps
module testbench
  import dts_pkg::*;
;
  logic            ref_clk, reset_n, transfer_busy, tunnel_busy, clear_invalid;
  logic            down_frame, down_slot, up_frame, up_slot, start, slow, fbusy;
  logic            spb, tact, inv, irq, abrt, flush, inv_exp;
  logic            pend_d = 1'b0;
  logic            pend_u = 1'b0;
  dts_dir_cfg_type down_cfg, up_cfg;
  dts_cmd_type     host_cmd;
  dts_slot_type    down_mark, up_mark;
  logic [7:0]      lfsr;
  logic [3:0]      roles [8] = '{4'h4, 4'hA, 4'h0, 4'h2, 4'h6, 4'h8, 4'h7, 4'hB};
  logic [7:0]      codes [4] = '{CMD_ABORT, 8'h00, 8'h10, 8'hFF};
  dts_slot_type    q_d [$];
  dts_slot_type    q_u [$];
  int              num_errors, total_checks, cnt_d, cnt_u;

  dts_slot_window dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .down_cfg(down_cfg),
    .up_cfg(up_cfg), .down_frame(down_frame), .down_slot(down_slot), .up_frame(up_frame),
    .up_slot(up_slot), .host_cmd(host_cmd), .transfer_busy(transfer_busy),
    .tunnel_busy(tunnel_busy), .clear_invalid(clear_invalid), .down_mark(down_mark),
    .up_mark(up_mark), .serial_port_busy(spb), .tunnel_active(tact),
    .invalid_command_flag(inv), .cmd_irq(irq), .abort_pulse(abrt), .fifo_flush(flush));

  dts_framer far_u (.ref_clk(ref_clk), .start(start), .slow(slow),
    .n_down(down_cfg.pass_slots + down_cfg.tunnel_slots),
    .n_up(up_cfg.pass_slots + up_cfg.tunnel_slots), .down_frame(down_frame),
    .down_slot(down_slot), .up_frame(up_frame), .up_slot(up_slot), .busy(fbusy));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------
  // reference model and checks
  // --------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // expected mark of slot idx: kind, tunnel bit and last-forwarded bit
  function automatic dts_slot_type exp_mark(dts_dir_cfg_type c, int idx);
    dts_slot_type m;
    int           lo;
    int           hi;
    lo = int'(c.offset);
    hi = int'(c.pass_slots) + int'(c.tunnel_slots);
    m.tunnel = (idx >= lo) && (idx < lo + int'(c.tunnel_slots));
    m.last = (idx == hi - 1);
    m.kind = (idx >= hi) ? SLOT_IDLE : (m.tunnel ? SLOT_TUNNEL : SLOT_AUDIO);
    if (m.tunnel && (c.first_node || c.last_node) && c.mask_enable && !c.relaxed) begin
      m.kind = SLOT_IDLE;
    end
    return m;
  endfunction

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // slot index follows frame and slot strobes; a frame wins
  // expected marks are queued at the slot edge and taken at the next falling edge
  always @(posedge ref_clk) begin
    pend_d <= down_slot & ~down_frame;
    pend_u <= up_slot & ~up_frame;
    if (down_slot && !down_frame) q_d.push_back(exp_mark(down_cfg, cnt_d));
    if (up_slot && !up_frame) q_u.push_back(exp_mark(up_cfg, cnt_u));
    cnt_d <= down_frame ? 0 : cnt_d + int'(down_slot);
    cnt_u <= up_frame ? 0 : cnt_u + int'(up_slot);
  end

  always @(negedge ref_clk) begin
    if (pend_d) chk("down_mark", 8'(q_d.pop_front()), 8'(down_mark));
    if (pend_u) chk("up_mark", 8'(q_u.pop_front()), 8'(up_mark));
  end

  task automatic mk_cfg(input logic [3:0] r, output dts_dir_cfg_type c);
    lfsr = lfsr_next(lfsr);
    c.pass_slots = 6'(lfsr[2:0]);
    c.tunnel_slots = 6'(lfsr[4:3]) + CNT_ONE;
    c.offset = 6'(int'(lfsr[7:5]) % (int'(lfsr[2:0]) + 1));
    {c.first_node, c.last_node, c.mask_enable, c.relaxed} = r;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(negedge ref_clk);
    while (fbusy && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (fbusy) chk("framer_busy", 8'h00, 8'h01);
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic cmd(logic [7:0] code, logic busy, logic tun);
    transfer_busy = busy;
    tunnel_busy = tun;
    repeat (2) @(negedge ref_clk);
    chk("serial_port_busy", 8'(busy), 8'(spb));
    chk("tunnel_active", 8'(tun), 8'(tact));
    host_cmd = '{1'b1, code};
    @(negedge ref_clk);
    host_cmd.valid = 1'b0;
    inv_exp = inv_exp | (busy && code != CMD_ABORT);
    chk("abort_pulse", 8'(busy && code == CMD_ABORT), 8'(abrt));
    chk("fifo_flush", 8'(busy && code == CMD_ABORT), 8'(flush));
    chk("cmd_irq", 8'(busy && code != CMD_ABORT), 8'(irq));
    chk("invalid_command_flag", 8'(inv_exp), 8'(inv));
    @(negedge ref_clk);
    chk("pulse_end", 8'h00, 8'({abrt, flush, irq}));
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {reset_n, transfer_busy, tunnel_busy, clear_invalid, start, slow, inv_exp} = 7'h00;
    {host_cmd, down_cfg, up_cfg} = '0;
    {num_errors, total_checks} = '0;
    lfsr = 8'h5C;
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    // node roles, offsets kept inside the passed window
    foreach (roles[k]) begin
      mk_cfg(roles[k], down_cfg);
      mk_cfg(roles[k], up_cfg);
      for (int s = 0; s < 2; s++) begin
        slow = s[0];
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        wait_idle();
      end
    end
    for (int b = 0; b < 4; b++) begin
      foreach (codes[k]) cmd(codes[k], b[0], b[1]);
    end
    // bad command and clear in one cycle: the set wins, the next clear takes it down
    host_cmd = '{1'b1, 8'h10};
    clear_invalid = 1'b1;
    @(negedge ref_clk);
    host_cmd.valid = 1'b0;
    chk("invalid_command_flag", 8'h01, 8'(inv));
    @(negedge ref_clk);
    clear_invalid = 1'b0;
    @(negedge ref_clk);
    chk("invalid_command_flag", 8'h00, 8'(inv));
    tally_and_finish();
  end

  initial begin
    #1000000;
    num_errors++;
    tally_and_finish();
  end
endmodule
